// >>> cpmix_component_mix.sv
`timescale 1ns/1ps
// Functional notes
// - Channel 3 gain code is sign bit 23h[0] above the eight bits of 24h.
// - Channel 4 gain code is sign bit 23h[1] above the eight bits of 25h.
// - With switch enable set, each pixel comes from composite or component by pin.
// - Polarity bit 0: low pin composite, high pin component; bit 1 inverts.
// - Switch pin timing shifts 0, +1, -2, -1 pixels versus component input.
// - Peaking bit adds component luma peaking, about +1.5 dB at 5 MHz.
// - Component delay codes give 0,+4,+8,+12,-16,-12,-8,-4 pixels versus composite.
// - Brightness is an unsigned offset, 128 nominal, 0 darkest, 255 brightest.
// - Contrast is a signed gain, 0x40 unity, 0x80 minus two, zero blanks luma.
// - Saturation scales chroma with the contrast coding; zero removes colour.
module cpmix_component_mix
  import cpmix_pkg::*;
#(
  parameter int DEPTH = LINE_DEPTH
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic         i_reg_wr,
  input  wire logic         i_reg_rd,
  input  wire logic [7:0]   i_reg_addr,
  input  wire logic [7:0]   i_reg_wdata,
  output logic      [7:0]   o_reg_rdata,
  input  wire cpmix_pixel_t i_cvbs_pixel,
  input  wire cpmix_pixel_t i_comp_pixel,
  input  wire logic         i_pixel_select_pin,
  output cpmix_pixel_t      o_pixel,
  output logic              o_pixel_is_comp,
  output logic      [8:0]   o_gain3_code,
  output logic      [8:0]   o_gain4_code
);

  localparam int TW = $clog2(DEPTH);

  // Clip a signed intermediate to 0..255
  function automatic logic [7:0] clip8(input logic signed [17:0] v);
    if (v < 0) begin
      return 8'h00;
    end else if (v > 255) begin
      return 8'hFF;
    end else begin
      return v[7:0];
    end
  endfunction : clip8

  // Signed gain with six fraction bits applied to a signed sample
  function automatic logic signed [17:0] scale(input logic signed [9:0] s,
                                               input logic [7:0] g);
    logic signed [17:0] p;
    p = 18'(s * $signed(g));
    return p >>> GAIN_FRAC_BITS;
  endfunction : scale

  // Register file
  logic [1:0] gain_sign;
  logic [7:0] gain3_low_reg;
  logic [7:0] gain4_low_reg;
  logic [7:0] switch_ctl;
  logic [7:0] comp_brightness;
  logic [7:0] comp_contrast;
  logic [7:0] comp_saturation;

  wire wr_sign = i_reg_wr && i_reg_addr == ADDR_GAIN_SIGN;
  wire wr_g3   = i_reg_wr && i_reg_addr == ADDR_GAIN3_LOW;
  wire wr_g4   = i_reg_wr && i_reg_addr == ADDR_GAIN4_LOW;
  wire wr_sw   = i_reg_wr && i_reg_addr == ADDR_SWITCH_CTL;
  wire wr_bri  = i_reg_wr && i_reg_addr == ADDR_BRIGHTNESS;
  wire wr_con  = i_reg_wr && i_reg_addr == ADDR_CONTRAST;
  wire wr_sat  = i_reg_wr && i_reg_addr == ADDR_SATURATION;

  // Writes land on the edge after the strobe
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gain_sign       <= RST_GAIN_SIGN;
      gain3_low_reg   <= RST_GAIN3_LOW;
      gain4_low_reg   <= RST_GAIN4_LOW;
      switch_ctl      <= RST_SWITCH_CTL;
      comp_brightness <= RST_BRIGHTNESS;
      comp_contrast   <= RST_CONTRAST;
      comp_saturation <= RST_SATURATION;
    end else begin
      if (wr_sign) gain_sign       <= i_reg_wdata[1:0];
      if (wr_g3)   gain3_low_reg   <= i_reg_wdata;
      if (wr_g4)   gain4_low_reg   <= i_reg_wdata;
      if (wr_sw)   switch_ctl      <= i_reg_wdata;
      if (wr_bri)  comp_brightness <= i_reg_wdata;
      if (wr_con)  comp_contrast   <= i_reg_wdata;
      if (wr_sat)  comp_saturation <= i_reg_wdata;
    end
  end

  // Read mux; only the two sign bits of 23h live here, the rest read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (i_reg_addr)
      ADDR_GAIN_SIGN:  rd_mux = {6'h00, gain_sign};
      ADDR_GAIN3_LOW:  rd_mux = gain3_low_reg;
      ADDR_GAIN4_LOW:  rd_mux = gain4_low_reg;
      ADDR_SWITCH_CTL: rd_mux = switch_ctl;
      ADDR_BRIGHTNESS: rd_mux = comp_brightness;
      ADDR_CONTRAST:   rd_mux = comp_contrast;
      ADDR_SATURATION: rd_mux = comp_saturation;
      default:         rd_mux = 8'h00;
    endcase
  end

  // Read data and gain codes are registered so outputs come from flops
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata  <= 8'h00;
      o_gain3_code <= 9'h000;
      o_gain4_code <= 9'h000;
    end else begin
      if (i_reg_rd) o_reg_rdata <= rd_mux;
      o_gain3_code <= {gain_sign[SIGN3_BIT], gain3_low_reg};
      o_gain4_code <= {gain_sign[SIGN4_BIT], gain4_low_reg};
    end
  end

  // Control fields
  wire       sw_en    = switch_ctl[SW_EN_BIT];
  wire       sw_pol   = switch_ctl[SW_POL_BIT];
  wire [1:0] sw_dly   = switch_ctl[SW_DLY_LSB +: 2];
  wire       peak_en  = switch_ctl[PEAK_BIT];
  wire [2:0] path_dly = switch_ctl[PATH_DLY_LSB +: 3];

  // Stage 1: three-tap luma window for peaking, chroma kept aligned with centre
  logic [7:0] luma_d1;
  logic [7:0] luma_d2;
  logic [7:0] chroma_d1;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      luma_d1   <= 8'h00;
      luma_d2   <= 8'h00;
      chroma_d1 <= 8'h00;
    end else begin
      luma_d1   <= i_comp_pixel.luma;
      luma_d2   <= luma_d1;
      chroma_d1 <= i_comp_pixel.chroma;
    end
  end

  // High-pass boost of 1/8 gives roughly +1.5 dB near the 5 MHz band
  wire signed [10:0] high_pass = 11'(2 * $signed({3'b000, luma_d1}))
                               - $signed({3'b000, luma_d2})
                               - $signed({3'b000, i_comp_pixel.luma});
  wire signed [17:0] peaked    = 18'($signed({1'b0, luma_d1})) + 18'(high_pass >>> PEAK_SHIFT);
  wire [7:0]  luma_pk = peak_en ? clip8(peaked) : luma_d1;

  // Contrast about black, then brightness offset from the neutral level
  wire signed [17:0] luma_scaled = scale($signed({2'b00, luma_pk}), comp_contrast);
  wire signed [17:0] luma_sum    = luma_scaled + 18'(comp_brightness)
                                 - 18'(NEUTRAL_LEVEL);
  // Chroma is offset binary, so gain applies around the neutral level
  wire signed [9:0]  chroma_s    = $signed({2'b00, chroma_d1}) - $signed({2'b00, NEUTRAL_LEVEL});
  wire signed [17:0] chroma_sum  = scale(chroma_s, comp_saturation)
                                 + 18'(NEUTRAL_LEVEL);

  // Stage 2: clipped component pixel
  cpmix_pixel_t comp_proc;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      comp_proc <= '0;
    end else begin
      comp_proc.luma   <= clip8(luma_sum);
      comp_proc.chroma <= clip8(chroma_sum);
    end
  end

  // Signed pixel offsets decoded from the two delay fields
  logic signed [5:0] path_off;
  logic signed [5:0] pin_off;
  always_comb begin
    case (path_dly)
      3'h0:    path_off = 6'sd0;
      3'h1:    path_off = 6'sd4;
      3'h2:    path_off = 6'sd8;
      3'h3:    path_off = 6'sd12;
      3'h4:    path_off = -6'sd16;
      3'h5:    path_off = -6'sd12;
      3'h6:    path_off = -6'sd8;
      default: path_off = -6'sd4;
    endcase
    case (sw_dly)
      2'h0:    pin_off = 6'sd0;
      2'h1:    pin_off = 6'sd1;
      2'h2:    pin_off = -6'sd2;
      default: pin_off = -6'sd1;
    endcase
  end

  // Composite waits a fixed time so negative component delays stay causal
  wire [TW-1:0] cvbs_tap = TW'(CVBS_TAP);
  wire [TW-1:0] comp_tap = TW'(COMP_BASE_TAP + 32'(path_off));
  // The pin follows the raw component timing, shifted by its own field
  wire [TW-1:0] pin_tap  = TW'(CVBS_TAP + 32'(path_off) + 32'(pin_off));

  cpmix_pixel_t cvbs_aligned;
  cpmix_pixel_t comp_aligned;
  logic         pin_aligned;

  cpmix_delay_line #(.WIDTH(16), .DEPTH(DEPTH)) u_cvbs_dly (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_data     (i_cvbs_pixel),
    .i_tap      (cvbs_tap),
    .o_data     (cvbs_aligned)
  );

  cpmix_delay_line #(.WIDTH(16), .DEPTH(DEPTH)) u_comp_dly (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_data     (comp_proc),
    .i_tap      (comp_tap),
    .o_data     (comp_aligned)
  );

  cpmix_delay_line #(.WIDTH(1), .DEPTH(DEPTH)) u_pin_dly (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_data     (i_pixel_select_pin),
    .i_tap      (pin_tap),
    .o_data     (pin_aligned)
  );

  // Per-pixel choice when enabled, else the polarity bit selects statically.
  // Mixing is only meaningful for sources locked to the composite input.
  wire pick_comp = sw_en ? (pin_aligned ^ sw_pol) : sw_pol;

  // Output pixel register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pixel         <= '0;
      o_pixel_is_comp <= 1'b0;
    end else begin
      o_pixel         <= pick_comp ? comp_aligned : cvbs_aligned;
      o_pixel_is_comp <= pick_comp;
    end
  end

endmodule : cpmix_component_mix

// >>> cpmix_pkg.sv
package cpmix_pkg;

  // Register subaddresses
  localparam logic [7:0] ADDR_GAIN_SIGN  = 8'h23;
  localparam logic [7:0] ADDR_GAIN3_LOW  = 8'h24;
  localparam logic [7:0] ADDR_GAIN4_LOW  = 8'h25;
  localparam logic [7:0] ADDR_SWITCH_CTL = 8'h29;
  localparam logic [7:0] ADDR_BRIGHTNESS = 8'h2A;
  localparam logic [7:0] ADDR_CONTRAST   = 8'h2B;
  localparam logic [7:0] ADDR_SATURATION = 8'h2C;

  // Reset values
  localparam logic [1:0] RST_GAIN_SIGN   = 2'h0;
  localparam logic [7:0] RST_GAIN3_LOW   = 8'h00;
  localparam logic [7:0] RST_GAIN4_LOW   = 8'h00;
  localparam logic [7:0] RST_SWITCH_CTL  = 8'h00;
  localparam logic [7:0] RST_BRIGHTNESS  = 8'h80;
  localparam logic [7:0] RST_CONTRAST    = 8'h40;
  localparam logic [7:0] RST_SATURATION  = 8'h40;

  // Field positions
  localparam int SIGN3_BIT       = 0;
  localparam int SIGN4_BIT       = 1;
  localparam int SW_EN_BIT       = 7;
  localparam int SW_POL_BIT      = 6;
  localparam int SW_DLY_LSB      = 4;
  localparam int PEAK_BIT        = 3;
  localparam int PATH_DLY_LSB    = 0;

  // Arithmetic constants
  localparam logic [7:0] NEUTRAL_LEVEL = 8'h80;  // Brightness and chroma zero point
  localparam int GAIN_FRAC_BITS  = 6;            // 0x40 is unity gain
  localparam int PEAK_SHIFT      = 3;            // High-pass weight 1/8

  // Delay line taps, in pixels
  localparam int PROC_LATENCY    = 2;            // Peaking plus gain stages
  localparam int COMP_BASE_TAP   = 18;           // Covers the -16 pixel code
  localparam int CVBS_TAP        = COMP_BASE_TAP + PROC_LATENCY;
  localparam int LINE_DEPTH      = 34;

  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } cpmix_pixel_t;

endpackage : cpmix_pkg

// >>> cpmix_delay_line.sv
`timescale 1ns/1ps
// Shift register with a run-time selectable tap; tap 0 is the input itself
module cpmix_delay_line #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 34
) (
  input  wire logic                     i_core_clk,
  input  wire logic                     i_rst,
  input  wire logic [WIDTH-1:0]         i_data,
  input  wire logic [$clog2(DEPTH)-1:0] i_tap,
  output wire logic [WIDTH-1:0]         o_data
);

  logic [WIDTH-1:0] stage [1:DEPTH-1];

  // Stage k holds the input of k cycles ago
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int k = 1; k < DEPTH; k++) begin
        stage[k] <= '0;
      end
    end else begin
      stage[1] <= i_data;
      for (int k = 2; k < DEPTH; k++) begin
        stage[k] <= stage[k-1];
      end
    end
  end

  // Out of range taps fall back to the undelayed input
  assign o_data = (i_tap == '0 || 32'(i_tap) >= DEPTH) ? i_data : stage[i_tap];

endmodule : cpmix_delay_line

// >>> cpmix_sva.sv
`timescale 1ns/1ps
// Port checker; shadows the switch register to know which source is selected
module cpmix_sva
  import cpmix_pkg::*;
(
  input wire logic         i_core_clk,
  input wire logic         i_rst,
  input wire logic         i_reg_wr,
  input wire logic         i_reg_rd,
  input wire logic [7:0]   i_reg_addr,
  input wire logic [7:0]   i_reg_wdata,
  input wire logic [7:0]   o_reg_rdata,
  input wire cpmix_pixel_t i_cvbs_pixel,
  input wire cpmix_pixel_t i_comp_pixel,
  input wire logic         i_pixel_select_pin,
  input wire cpmix_pixel_t o_pixel,
  input wire logic         o_pixel_is_comp,
  input wire logic [8:0]   o_gain3_code,
  input wire logic [8:0]   o_gain4_code
);
  logic [7:0] ctl;
  logic [5:0] quiet;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // Quiet saturates only once the longest delay tap has flushed old settings
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl   <= 8'h00;
      quiet <= 6'h00;
    end else if (i_reg_wr && i_reg_addr == ADDR_SWITCH_CTL) begin
      ctl   <= i_reg_wdata;
      quiet <= 6'h00;
    end else if (quiet != 6'h3F) begin
      quiet <= quiet + 6'h01;
    end
  end
  sequence s_wr(a);
    i_reg_wr && i_reg_addr == a;
  endsequence
  chk_gain3_low: assert property (
    s_wr(ADDR_GAIN3_LOW) |-> ##2 o_gain3_code[7:0] == $past(i_reg_wdata, 2))
    else $error("gain3 low bits wrong");
  chk_gain4_low: assert property (
    s_wr(ADDR_GAIN4_LOW) |-> ##2 o_gain4_code[7:0] == $past(i_reg_wdata, 2))
    else $error("gain4 low bits wrong");
  chk_gain_signs: assert property (
    s_wr(ADDR_GAIN_SIGN) |-> ##2 o_gain3_code[8] == $past(i_reg_wdata[0], 2)
      && o_gain4_code[8] == $past(i_reg_wdata[1], 2))
    else $error("gain sign bits wrong");
  chk_static_sel: assert property (
    quiet == 6'h3F && !ctl[7] |-> o_pixel_is_comp == ctl[6])
    else $error("static source wrong");
  chk_fast_sel: assert property (
    quiet == 6'h3F && ctl[7] && ctl[5:4] == 2'h0
      |-> o_pixel_is_comp == ($past(i_pixel_select_pin, 21) ^ ctl[6]))
    else $error("pixel switch wrong");
  chk_cvbs_path: assert property (
    quiet == 6'h3F && ctl[7:6] == 2'h0 |-> o_pixel == $past(i_cvbs_pixel, 21))
    else $error("composite path wrong");
  chk_reset_out: assert property (
    $fell(i_rst) |-> (o_pixel == 16'h0000 && !o_pixel_is_comp) [*8])
    else $error("pixel not clear after reset");
  chk_rdata_hold: assert property (
    !i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved");
  chk_unmapped_rd: assert property (
    i_reg_rd && i_reg_addr > ADDR_SATURATION |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule : cpmix_sva
bind cpmix_component_mix cpmix_sva u_sva (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_cvbs_pixel(i_cvbs_pixel), .i_comp_pixel(i_comp_pixel), .o_pixel(o_pixel),
  .i_pixel_select_pin(i_pixel_select_pin), .o_pixel_is_comp(o_pixel_is_comp),
  .o_gain3_code(o_gain3_code), .o_gain4_code(o_gain4_code));

// >>> cpmix_host.sv
`timescale 1ns/1ps
// Host controller model; released lines show the inverse of the last value
module cpmix_host
  import cpmix_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic [7:0]  i_reg_rdata,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic      [7:0] o_reg_addr,
  output logic      [7:0] o_reg_wdata
);
  initial begin
    {o_reg_wr, o_reg_rd, o_reg_addr, o_reg_wdata} = 18'h00000;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    {o_reg_wr, o_reg_addr, o_reg_wdata} <= {1'b1, a, d};
    @(posedge i_core_clk);
    {o_reg_wr, o_reg_addr, o_reg_wdata} <= {1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge i_core_clk);
    {o_reg_rd, o_reg_addr} <= {1'b1, a};
    @(posedge i_core_clk);
    {o_reg_rd, o_reg_addr} <= {1'b0, ~a};
    @(negedge i_core_clk);
    q = i_reg_rdata;
  endtask : rd
  // Static source follows the input mode, upper half of modes is component
  task automatic sel(input logic [5:0] mode, input logic [5:0] low);
    wr(ADDR_SWITCH_CTL, {1'b0, mode >= 6'h20, low});
  endtask : sel
  // Only called while the component stream is locked to the composite one
  task automatic pixel_select_pin(input logic pol, input logic [1:0] dly);
    wr(ADDR_SWITCH_CTL, {1'b1, pol, dly, 4'h0});
  endtask : pixel_select_pin
endmodule : cpmix_host

// >>> test_component_path_mix_control.sv
`timescale 1ns/1ps
module test_component_path_mix_control
  import cpmix_pkg::*;
;
  logic         i_core_clk, i_rst, pin, hold, is_comp, wr, rd, e;
  logic [7:0]   q, addr, wdata, rdata;
  logic [8:0]   g3, g4;
  cpmix_pixel_t cv, cp, hp, o_pixel, pa, pb, pc;
  int           cyc, err_count, num_checks, n, pk;
  // Rows: address, write data, reset value, read-back value
  logic [31:0]  rows [8] = '{32'h23FE0002, 32'h24900090, 32'h25FF00FF, 32'h29400040,
                           32'h2A908090, 32'h2BC040C0, 32'h2C004000, 32'h30550000};
  // Cases: luma, chroma, brightness, contrast, saturation, expected luma, chroma
  logic [55:0]  bcs [3] = '{56'hF090FF7F7FFF9F, 56'h40908080C00070, 56'h50209040006080};
  int           offs [8] = '{0, 4, 8, 12, -16, -12, -8, -4};
  int           late [4] = '{0, 1, -2, -1};
  function automatic cpmix_pixel_t px(int k, bit c);
    logic [7:0] b;
    b = k[7:0];
    return c ? {b ^ 8'h5A, b} : {b, ~b};
  endfunction : px
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  // Both streams are ramps keyed to the cycle count, except component while hold feeds hp, so lateness is computable
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    cv  <= px(cyc, 1'b0);
    cp  <= hold ? hp : px(cyc, 1'b1);
    pin <= cyc[2];
  end
  cpmix_host u_host (.i_core_clk(i_core_clk), .i_reg_rdata(rdata), .o_reg_wr(wr),
    .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata));
  cpmix_component_mix u_dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_cvbs_pixel(cv), .i_comp_pixel(cp), .i_pixel_select_pin(pin), .o_pixel(o_pixel),
    .o_pixel_is_comp(is_comp), .o_gain3_code(g3), .o_gain4_code(g4));
  initial begin
    // Pixel streams and the pin belong to the stimulus process alone
    {i_rst, hold, hp} = {1'b1, 1'b0, 16'h0000};
    {err_count, num_checks} = '0;
    repeat (2) @(posedge i_core_clk);
    i_rst <= 1'b0;
    foreach (rows[i]) begin
      u_host.rd(rows[i][31:24], q);
      chk(q, rows[i][15:8]);
      u_host.wr(rows[i][31:24], rows[i][23:16]);
      u_host.rd(rows[i][31:24], q);
      chk(q, rows[i][7:0]);
    end
    chk(g3, 9'h090);
    chk(g4, 9'h1FF);
    u_host.wr(ADDR_BRIGHTNESS, 8'h80);
    u_host.wr(ADDR_CONTRAST, 8'h40);
    u_host.wr(ADDR_SATURATION, 8'h40);
    u_host.sel(6'h05, 6'h00);
    // Long enough for the checker's quiet counter to saturate
    repeat (64) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk(o_pixel, px(cyc - 22, 1'b0));
    // Every component offset code, static component selection
    for (int k = 0; k < 8; k++) begin
      u_host.sel(6'h25, k[5:0]);
      repeat (40) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk(o_pixel, px(cyc - 22 - offs[k], 1'b1));
    end
    // Every polarity and pin timing code with the pin toggling every 4 pixels
    for (int k = 0; k < 8; k++) begin
      u_host.pixel_select_pin(k[2], k[1:0]);
      repeat (64) @(posedge i_core_clk);
      repeat (8) begin
        @(negedge i_core_clk);
        n = cyc - 22 - late[k % 4];
        e = n[2] ^ k[2];
        chk(is_comp, e);
        chk(o_pixel, px(cyc - 22, e));
      end
    end
    // Flat component input isolates brightness, gain and clipping from peaking
    u_host.wr(ADDR_SWITCH_CTL, 8'h48);
    // Ramp input with peaking on; the high-pass term is modelled on its own
    repeat (64) @(posedge i_core_clk);
    repeat (8) begin
      @(negedge i_core_clk);
      n  = cyc - 22;
      pa = px(n - 1, 1'b1);
      pb = px(n, 1'b1);
      pc = px(n + 1, 1'b1);
      pk = 2 * int'(pb.luma) - int'(pa.luma) - int'(pc.luma);
      pk = int'(pb.luma) + (pk >>> PEAK_SHIFT);
      pk = (pk < 0) ? 0 : ((pk > 255) ? 255 : pk);
      chk(o_pixel, {pk[7:0], pb.chroma});
    end
    foreach (bcs[i]) begin
      hold <= 1'b1;
      hp   <= bcs[i][55:40];
      u_host.wr(ADDR_BRIGHTNESS, bcs[i][39:32]);
      u_host.wr(ADDR_CONTRAST, bcs[i][31:24]);
      u_host.wr(ADDR_SATURATION, bcs[i][23:16]);
      repeat (30) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk(o_pixel, bcs[i][15:0]);
    end
    @(posedge i_core_clk);
    i_rst <= 1'b1;
    @(negedge i_core_clk);
    chk({g3, g4}, 18'h00000);
    chk({rdata, is_comp, o_pixel}, 25'h0000000);
    @(posedge i_core_clk);
    i_rst <= 1'b0;
    u_host.rd(ADDR_BRIGHTNESS, q);
    chk(q, RST_BRIGHTNESS);
    wrap_up;
  end
endmodule : test_component_path_mix_control
